// ==== zsram_pkg.sv ====
// Shared constants and types for the pipelined late-write static memory and its controller
package zsram_pkg;
  localparam int DATA_W_DEF = 36;
  localparam int ADDR_W_DEF = 17;
  localparam int LANES_DEF = 4;
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_START = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  localparam logic LOAD_NEW = 1'b0;
  localparam logic ADVANCE = 1'b1;
  localparam logic SEL_N_ON = 1'b0;
  localparam logic SEL_N_OFF = 1'b1;
  localparam logic SEL_HI_ON = 1'b1;
  localparam logic OE_HELD_ON_N = 1'b0;
  localparam logic SNOOZE_OFF = 1'b0;
  typedef enum logic [1:0] {OP_IDLE = 2'b00, OP_READ = 2'b01, OP_WRITE = 2'b10} op_t;
endpackage

// ==== zsram_link_if.sv ====
// Pin-level link between the memory controller and the static memory
`timescale 1ns/10ps
interface zsram_link_if #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 17,
  parameter int LANES = 4
);
  logic [ADDR_W-1:0] word_address;
  logic read_write_n;
  logic load_or_advance_n;
  logic chip_select_n;
  logic chip_select_expand_n;
  logic chip_select_expand_hi;
  logic [LANES-1:0] byte_lane_write_n;
  logic clock_enable_n;
  logic output_enable_n;
  logic snooze_request;
  logic burst_order_interleave;
  logic [DATA_W-1:0] ctl_data;
  logic ctl_data_oe;
  logic [DATA_W-1:0] mem_data;
  logic mem_data_oe;
  logic [DATA_W-1:0] data_line;

  // Shared data wire; contention never arises when both ends keep the slot plan
  assign data_line = mem_data_oe ? mem_data : (ctl_data_oe ? ctl_data : '0);

  modport memory (
    input word_address, read_write_n, load_or_advance_n, chip_select_n, chip_select_expand_n,
    input chip_select_expand_hi, byte_lane_write_n, clock_enable_n, output_enable_n,
    input snooze_request, burst_order_interleave, data_line,
    output mem_data, mem_data_oe
  );
  modport ctrl (
    output word_address, read_write_n, load_or_advance_n, chip_select_n, chip_select_expand_n,
    output chip_select_expand_hi, byte_lane_write_n, clock_enable_n, output_enable_n,
    output snooze_request, burst_order_interleave, ctl_data, ctl_data_oe,
    input data_line
  );
endinterface

// ==== zsram_device.sv ====
// Pipelined static memory with late-late write and no bus turnaround
// Function
// - All synchronous inputs registered on rising edge
// - Read and write back to back, no idle
// - Controller gives write data two edges later
// - Byte enables travel with the write address
// - Cycle type set only when address loads
// - Burst continuation addresses come from internal counter
// - Fresh address every cycle is also legal
// - Two-bit counter wraps after four accesses
// - Static select picks interleaved or linear order
// - Registered read data gated by output enable
// - Controller may hold output enable low
// - Each active-low byte enable writes its lane
// - Array write self-timed once delayed data arrives
// - Array 256Kx18 or 128Kx32/36, parity lanes
// - Controller holds snooze low when unused
// - Snooze keeps contents and ignores inputs
// - Clock enable high freezes all internal state
// - Three chip selects take effect only on load
// - Advance ignores read/write and continues burst
//
`timescale 1ns/10ps
module zsram_device
  import zsram_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES = LANES_DEF
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  zsram_link_if.memory link
);
  localparam int LANE_W = DATA_W / LANES;
  localparam int DEPTH = 2 ** ADDR_W;

  ////////////////////////////////////////////////////////////////////////////
  // State
  // Words of 18 bits carry two 9-bit lanes, 36 bits four 9-bit lanes, 32 bits four 8-bit lanes
  logic [DATA_W-1:0] array_mem [DEPTH];

  logic [ADDR_W-1:0] in_addr_q, in_addr_d;
  logic in_rw_q, in_rw_d;
  logic in_ld_n_q, in_ld_n_d;
  logic in_cs_n_q, in_cs_n_d;
  logic in_cs2_n_q, in_cs2_n_d;
  logic in_cs2_q, in_cs2_d;
  logic [LANES-1:0] in_be_n_q, in_be_n_d;
  logic [DATA_W-1:0] in_data_q, in_data_d;

  op_t bst_op_q, bst_op_d;
  logic [ADDR_W-1:0] bst_base_q, bst_base_d;
  logic [BURST_W-1:0] bst_cnt_q, bst_cnt_d;

  op_t s1_op_q, s1_op_d;
  logic [ADDR_W-1:0] s1_addr_q, s1_addr_d;
  logic [LANES-1:0] s1_be_n_q, s1_be_n_d;
  op_t s2_op_q, s2_op_d;
  logic [ADDR_W-1:0] s2_addr_q, s2_addr_d;
  logic [LANES-1:0] s2_be_n_q, s2_be_n_d;

  logic [DATA_W-1:0] out_q, out_d;
  logic out_oe_q, out_oe_d;

  logic live;
  op_t cmd_op;
  logic [ADDR_W-1:0] cmd_base;
  logic [ADDR_W-1:0] cmd_addr;
  logic [BURST_W-1:0] cmd_cnt;
  logic [BURST_W-1:0] cmd_low;
  logic selected;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] merged;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode from the input registers
  // Snooze or a high clock enable turns the edge into a no-op for every register except out_oe_q, which snooze clears
  assign live = ~link.clock_enable_n & ~link.snooze_request;
  assign selected = (in_cs_n_q == SEL_N_ON) && (in_cs2_n_q == SEL_N_ON) && (in_cs2_q == SEL_HI_ON);

  always_comb
  begin
    cmd_op = bst_op_q;
    cmd_base = bst_base_q;
    cmd_cnt = bst_cnt_q + BURST_STEP;
    if (in_ld_n_q == LOAD_NEW)
    begin
      cmd_base = in_addr_q;
      cmd_cnt = BURST_START;
      if (!selected)
        cmd_op = OP_IDLE;
      else if (in_rw_q == RW_READ)
        cmd_op = OP_READ;
      else
        cmd_op = OP_WRITE;
    end
    if (link.burst_order_interleave)
      cmd_low = cmd_base[BURST_W-1:0] ^ cmd_cnt;
    else
      cmd_low = cmd_base[BURST_W-1:0] + cmd_cnt;
    cmd_addr = {cmd_base[ADDR_W-1:BURST_W], cmd_low};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path with forwarding from writes not yet in the array
  assign rd_word = array_mem[cmd_addr];

  // The write one slot older has its data on the pins right now, so it wins over the older one
  for (genvar l = 0; l < LANES; l++)
  begin : g_lane_fwd
    logic fwd_new;
    logic fwd_old;
    assign fwd_new = (s1_op_q == OP_WRITE) && (s1_addr_q == cmd_addr) && !s1_be_n_q[l];
    assign fwd_old = (s2_op_q == OP_WRITE) && (s2_addr_q == cmd_addr) && !s2_be_n_q[l];
    assign merged[l*LANE_W +: LANE_W] = fwd_new ? link.data_line[l*LANE_W +: LANE_W] :
      (fwd_old ? in_data_q[l*LANE_W +: LANE_W] : rd_word[l*LANE_W +: LANE_W]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    in_addr_d = in_addr_q;
    in_rw_d = in_rw_q;
    in_ld_n_d = in_ld_n_q;
    in_cs_n_d = in_cs_n_q;
    in_cs2_n_d = in_cs2_n_q;
    in_cs2_d = in_cs2_q;
    in_be_n_d = in_be_n_q;
    in_data_d = in_data_q;
    bst_op_d = bst_op_q;
    bst_base_d = bst_base_q;
    bst_cnt_d = bst_cnt_q;
    s1_op_d = s1_op_q;
    s1_addr_d = s1_addr_q;
    s1_be_n_d = s1_be_n_q;
    s2_op_d = s2_op_q;
    s2_addr_d = s2_addr_q;
    s2_be_n_d = s2_be_n_q;
    out_d = out_q;
    out_oe_d = out_oe_q;
    if (link.snooze_request)
      out_oe_d = 1'b0;
    else if (live)
    begin
      in_addr_d = link.word_address;
      in_rw_d = link.read_write_n;
      in_ld_n_d = link.load_or_advance_n;
      in_cs_n_d = link.chip_select_n;
      in_cs2_n_d = link.chip_select_expand_n;
      in_cs2_d = link.chip_select_expand_hi;
      in_be_n_d = link.byte_lane_write_n;
      in_data_d = link.data_line;
      bst_op_d = cmd_op;
      bst_base_d = cmd_base;
      bst_cnt_d = cmd_cnt;
      s1_op_d = cmd_op;
      s1_addr_d = cmd_addr;
      s1_be_n_d = in_be_n_q;
      s2_op_d = s1_op_q;
      s2_addr_d = s1_addr_q;
      s2_be_n_d = s1_be_n_q;
      // Read launched one edge after decode lands in the same slot as late write data
      out_d = merged;
      out_oe_d = (cmd_op == OP_READ) && !link.output_enable_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      in_addr_q <= '0;
      in_rw_q <= RW_READ;
      in_ld_n_q <= ADVANCE;
      in_cs_n_q <= SEL_N_OFF;
      in_cs2_n_q <= SEL_N_OFF;
      in_cs2_q <= ~SEL_HI_ON;
      in_be_n_q <= '1;
      in_data_q <= '0;
      bst_op_q <= OP_IDLE;
      bst_base_q <= '0;
      bst_cnt_q <= BURST_START;
      s1_op_q <= OP_IDLE;
      s1_addr_q <= '0;
      s1_be_n_q <= '1;
      s2_op_q <= OP_IDLE;
      s2_addr_q <= '0;
      s2_be_n_q <= '1;
      out_q <= '0;
      out_oe_q <= 1'b0;
    end
    else
    begin
      in_addr_q <= in_addr_d;
      in_rw_q <= in_rw_d;
      in_ld_n_q <= in_ld_n_d;
      in_cs_n_q <= in_cs_n_d;
      in_cs2_n_q <= in_cs2_n_d;
      in_cs2_q <= in_cs2_d;
      in_be_n_q <= in_be_n_d;
      in_data_q <= in_data_d;
      bst_op_q <= bst_op_d;
      bst_base_q <= bst_base_d;
      bst_cnt_q <= bst_cnt_d;
      s1_op_q <= s1_op_d;
      s1_addr_q <= s1_addr_d;
      s1_be_n_q <= s1_be_n_d;
      s2_op_q <= s2_op_d;
      s2_addr_q <= s2_addr_d;
      s2_be_n_q <= s2_be_n_d;
      out_q <= out_d;
      out_oe_q <= out_oe_d;
    end
  end

  // Array has no reset; contents are whatever was last written
  always_ff @(posedge i_clk_sys)
  begin
    if (live && s2_op_q == OP_WRITE)
    begin
      for (int l = 0; l < LANES; l++)
      begin
        if (!s2_be_n_q[l])
          array_mem[s2_addr_q][l*LANE_W +: LANE_W] <= in_data_q[l*LANE_W +: LANE_W];
      end
    end
  end

  assign link.mem_data = out_q;
  assign link.mem_data_oe = out_oe_q;
endmodule

// ==== zsram_ctrl.sv ====
// Memory controller end: turns user requests into pin cycles with late-late write data
`timescale 1ns/10ps
module zsram_ctrl
  import zsram_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEF,
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int LANES = LANES_DEF
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic i_req_burst,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic [DATA_W-1:0] i_req_wdata,
  input wire logic [LANES-1:0] i_req_be,
  input wire logic i_suspend,
  input wire logic i_burst_interleave,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [DATA_W-1:0] o_rsp_rdata,
  zsram_link_if.ctrl link
);
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic rw_q, rw_d;
  logic ld_n_q, ld_n_d;
  logic cs_n_q, cs_n_d;
  logic cs_hi_q, cs_hi_d;
  logic [LANES-1:0] be_n_q, be_n_d;
  logic cke_n_q, cke_n_d;
  logic ready_q, ready_d;
  logic mode_q, mode_d;
  op_t cur_op_q, cur_op_d;
  op_t p1_op_q, p1_op_d;
  op_t p2_op_q, p2_op_d;
  op_t p3_op_q, p3_op_d;
  logic [DATA_W-1:0] p1_data_q, p1_data_d;
  logic [DATA_W-1:0] p2_data_q, p2_data_d;
  logic [DATA_W-1:0] dout_q, dout_d;
  logic dout_oe_q, dout_oe_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  op_t op;
  logic take;

  ////////////////////////////////////////////////////////////////////////////
  // Next state; the whole pipeline freezes on edges the memory ignores
  always_comb
  begin
    addr_d = addr_q;
    rw_d = rw_q;
    ld_n_d = ld_n_q;
    cs_n_d = cs_n_q;
    cs_hi_d = cs_hi_q;
    be_n_d = be_n_q;
    cur_op_d = cur_op_q;
    p1_op_d = p1_op_q;
    p2_op_d = p2_op_q;
    p3_op_d = p3_op_q;
    p1_data_d = p1_data_q;
    p2_data_d = p2_data_q;
    dout_d = dout_q;
    dout_oe_d = dout_oe_q;
    rdata_d = rdata_q;
    rsp_valid_d = 1'b0;
    cke_n_d = i_suspend;
    ready_d = ~i_suspend;
    mode_d = i_burst_interleave;
    take = i_req_valid && ready_q;
    op = OP_IDLE;
    if (!cke_n_q)
    begin
      if (take && i_req_burst && cur_op_q != OP_IDLE)
      begin
        op = cur_op_q;
        ld_n_d = ADVANCE;
      end
      else
      begin
        op = !take ? OP_IDLE : (i_req_write ? OP_WRITE : OP_READ);
        ld_n_d = LOAD_NEW;
        cs_n_d = take ? SEL_N_ON : SEL_N_OFF;
        cs_hi_d = take ? SEL_HI_ON : ~SEL_HI_ON;
        addr_d = i_req_addr;
        rw_d = i_req_write ? RW_WRITE : RW_READ;
        cur_op_d = op;
      end
      be_n_d = (op == OP_WRITE) ? ~i_req_be : '1;
      p1_op_d = op;
      p1_data_d = i_req_wdata;
      p2_op_d = p1_op_q;
      p2_data_d = p1_data_q;
      p3_op_d = p2_op_q;
      // Write data goes out two edges after its address, in the slot a read would use
      dout_d = p2_data_q;
      dout_oe_d = (p2_op_q == OP_WRITE);
      rsp_valid_d = (p3_op_q == OP_READ);
      rdata_d = link.data_line;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      addr_q <= '0;
      rw_q <= RW_READ;
      ld_n_q <= LOAD_NEW;
      cs_n_q <= SEL_N_OFF;
      cs_hi_q <= ~SEL_HI_ON;
      be_n_q <= '1;
      cke_n_q <= 1'b0;
      ready_q <= 1'b0;
      mode_q <= 1'b0;
      cur_op_q <= OP_IDLE;
      p1_op_q <= OP_IDLE;
      p2_op_q <= OP_IDLE;
      p3_op_q <= OP_IDLE;
      p1_data_q <= '0;
      p2_data_q <= '0;
      dout_q <= '0;
      dout_oe_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      addr_q <= addr_d;
      rw_q <= rw_d;
      ld_n_q <= ld_n_d;
      cs_n_q <= cs_n_d;
      cs_hi_q <= cs_hi_d;
      be_n_q <= be_n_d;
      cke_n_q <= cke_n_d;
      ready_q <= ready_d;
      mode_q <= mode_d;
      cur_op_q <= cur_op_d;
      p1_op_q <= p1_op_d;
      p2_op_q <= p2_op_d;
      p3_op_q <= p3_op_d;
      p1_data_q <= p1_data_d;
      p2_data_q <= p2_data_d;
      dout_q <= dout_d;
      dout_oe_q <= dout_oe_d;
      rsp_valid_q <= rsp_valid_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  assign link.word_address = addr_q;
  assign link.read_write_n = rw_q;
  assign link.load_or_advance_n = ld_n_q;
  assign link.chip_select_n = cs_n_q;
  assign link.chip_select_expand_n = cs_n_q;
  assign link.chip_select_expand_hi = cs_hi_q;
  assign link.byte_lane_write_n = be_n_q;
  assign link.clock_enable_n = cke_n_q;
  assign link.output_enable_n = OE_HELD_ON_N;
  assign link.snooze_request = SNOOZE_OFF;
  assign link.burst_order_interleave = mode_q;
  assign link.ctl_data = dout_q;
  assign link.ctl_data_oe = dout_oe_q;
  assign o_req_ready = ready_q;
  assign o_rsp_valid = rsp_valid_q;
  assign o_rsp_rdata = rdata_q;
endmodule

// ==== zsram_link_monitor.sv ====
// Checker watching the pin link between controller and memory
`timescale 1ns/10ps
module zsram_link_monitor
  import zsram_pkg::*;
#(
  parameter int DATA_W = 36
)
(
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_read_write_n,
  input wire logic i_load_or_advance_n,
  input wire logic i_chip_select_n,
  input wire logic i_chip_select_expand_n,
  input wire logic i_chip_select_expand_hi,
  input wire logic i_clock_enable_n,
  input wire logic i_output_enable_n,
  input wire logic i_snooze_request,
  input wire logic i_ctl_data_oe,
  input wire logic i_mem_data_oe,
  input wire logic [DATA_W-1:0] i_mem_data
);
  default clocking mon_cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  logic live;
  logic sel_on;
  assign live = !i_clock_enable_n && (i_snooze_request == SNOOZE_OFF);
  assign sel_on = !i_chip_select_n && !i_chip_select_expand_n && i_chip_select_expand_hi;

  ////////////////////////////////////////////////////////////////////////////////
  // A live edge that loads a new, selected cycle of the given type
  sequence load_s(logic rw);
    live && i_load_or_advance_n == LOAD_NEW && sel_on && i_read_write_n == rw;
  endsequence
  sequence launch_s;
    live && !i_output_enable_n;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  rd_pipe_a: assert property (load_s(RW_READ) ##1 launch_s |-> ##1 i_mem_data_oe)
    else $error("read data not driven two edges after load");
  burst_adv_a: assert property (load_s(RW_READ) ##1 (live && i_load_or_advance_n == ADVANCE) ##1 launch_s
    |-> ##1 i_mem_data_oe)
    else $error("burst advance did not continue the read");
  wr_gap_a: assert property (load_s(RW_WRITE) ##1 live |-> ##1 !i_mem_data_oe)
    else $error("memory drove the bus in a write data slot");
  wr_slot_a: assert property (load_s(RW_WRITE) ##1 live |-> ##1 i_ctl_data_oe)
    else $error("write data not given two edges after address");
  desel_quiet_a: assert property ((live && i_load_or_advance_n == LOAD_NEW && !sel_on) ##1 live
    |-> ##1 !i_mem_data_oe)
    else $error("deselected memory drove the bus");
  oe_gate_a: assert property (i_mem_data_oe |-> $past(i_output_enable_n) == 1'b0)
    else $error("memory drove with output enable off");
  stall_hold_a: assert property (i_clock_enable_n |=> $stable(i_mem_data_oe) && $stable(i_mem_data))
    else $error("memory moved on an ignored edge");
  bus_clash_a: assert property (!(i_mem_data_oe && i_ctl_data_oe))
    else $error("both ends drive the data bus");
endmodule

// ==== testbench.sv ====
// Self-checking bench: controller and memory joined over the pin link
`timescale 1ns/10ps
module testbench;
  import zsram_pkg::*;
  typedef struct packed {logic w; logic b; logic [16:0] a; logic [35:0] d; logic [3:0] e;} row_t;
  typedef struct {logic [35:0] d; int c;} exp_t;
  logic i_clk_sys, i_reset_n, i_req_valid, i_req_write, i_req_burst, i_suspend, i_burst_interleave;
  logic [16:0] i_req_addr;
  logic [35:0] i_req_wdata;
  logic [3:0] i_req_be;
  logic o_req_ready, o_rsp_valid;
  logic [35:0] o_rsp_rdata;
  logic [35:0] shadow [int];
  logic [16:0] base;
  exp_t exp_q [$];
  exp_t e;
  int fails = 0, tests_run = 0, cyc = 0, beat = 0, stall = 0;
  // Read rows carry the word they must return
  row_t rows [7] = '{
    '{1'h1, 1'h0, 17'h00010, 36'h9_8765_4321, 4'hf},
    '{1'h0, 1'h0, 17'h00010, 36'h9_8765_4321, 4'h0},
    '{1'h1, 1'h0, 17'h00010, 36'h0_00ff_00ff, 4'h5},
    '{1'h0, 1'h0, 17'h00010, 36'h9_80fd_42ff, 4'h0},
    '{1'h1, 1'h0, 17'h00011, 36'ha_bcde_f012, 4'hf},
    '{1'h0, 1'h0, 17'h00010, 36'h9_80fd_42ff, 4'h0},
    '{1'h0, 1'h0, 17'h00011, 36'ha_bcde_f012, 4'h0}};

  zsram_link_if u_zsram_link_if ();
  zsram_ctrl u_zsram_ctrl (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_req_valid(i_req_valid),
    .i_req_write(i_req_write), .i_req_burst(i_req_burst), .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata),
    .i_req_be(i_req_be), .i_suspend(i_suspend), .i_burst_interleave(i_burst_interleave),
    .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata), .link(u_zsram_link_if));
  zsram_device u_zsram_device (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .link(u_zsram_link_if));
  zsram_link_monitor u_zsram_link_monitor (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_read_write_n(u_zsram_link_if.read_write_n), .i_load_or_advance_n(u_zsram_link_if.load_or_advance_n),
    .i_chip_select_n(u_zsram_link_if.chip_select_n), .i_chip_select_expand_n(u_zsram_link_if.chip_select_expand_n),
    .i_chip_select_expand_hi(u_zsram_link_if.chip_select_expand_hi),
    .i_clock_enable_n(u_zsram_link_if.clock_enable_n),
    .i_output_enable_n(u_zsram_link_if.output_enable_n), .i_snooze_request(u_zsram_link_if.snooze_request),
    .i_ctl_data_oe(u_zsram_link_if.ctl_data_oe), .i_mem_data_oe(u_zsram_link_if.mem_data_oe),
    .i_mem_data(u_zsram_link_if.mem_data));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Holds the request until taken; valid stays up so back-to-back calls never double-drive it
  task automatic req(input row_t r, input logic own);
    logic [16:0] ea;
    logic rdy;
    int k;
    i_req_valid <= 1'b1;
    {i_req_write, i_req_burst, i_req_addr, i_req_wdata, i_req_be} <= r;
    beat = r.b ? beat + 1 : 0;
    if (!r.b)
      base = r.a;
    ea = {base[16:2], i_burst_interleave ? base[1:0] ^ beat[1:0] : base[1:0] + beat[1:0]};
    for (k = 0; k < 20; k++)
    begin
      @(negedge i_clk_sys);
      rdy = o_req_ready;
      @(posedge i_clk_sys);
      if (rdy === 1'b1)
        break;
    end
    if (k == 20)
    begin
      check(1'b0, "request never taken");
      test_done();
    end
    else if (r.w)
    begin
      for (k = 0; k < 4; k++)
        if (r.e[k])
          shadow[ea][k*9+:9] = r.d[k*9+:9];
    end
    else
      exp_q.push_back('{own ? r.d : shadow[ea], stall ? 0 : cyc + 4});
  endtask

  task automatic idle(input int n);
    i_req_valid <= 1'b0;
    repeat (n) @(posedge i_clk_sys);
  endtask

  task automatic drain();
    for (int n = 0; n < 20 && exp_q.size() != 0; n++)
      @(posedge i_clk_sys);
    check(exp_q.size() == 0, "read answer missing");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  always @(posedge i_clk_sys)
    cyc <= cyc + 1;

  always @(negedge i_clk_sys)
    if (o_rsp_valid === 1'b1)
    begin
      e = '{36'hx, -1};
      if (exp_q.size() != 0)
        e = exp_q.pop_front();
      check(o_rsp_rdata === e.d && (e.c == 0 || e.c == cyc), "read data or timing wrong");
    end

  initial
  begin
    {i_req_valid, i_suspend, i_burst_interleave} = 3'h0;
    {i_req_write, i_req_burst, i_req_addr, i_req_wdata, i_req_be} = '0;
    i_reset_n = 1'b0;
    repeat (20) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    @(posedge i_clk_sys);
    foreach (rows[i])
      req(rows[i], 1'b1);
    for (int n = 0; n < 5; n++)
      req('{1'h1, n != 0, 17'h00032, 36'h0_0000_00a0 + n, 4'hf}, 1'b0);
    for (int n = 0; n < 4; n++)
      req('{1'h0, 1'h0, 17'(17'h00030 + n), 36'h0, 4'hf}, 1'b0);
    i_burst_interleave <= 1'b1;
    idle(4);
    for (int n = 0; n < 4; n++)
      req('{1'h0, n != 0, 17'h00031, 36'h0, 4'hf}, 1'b0);
    // Stall mid-stream: latency is not checked, only that the data survive and ready drops while suspended
    stall = 1;
    fork
      begin
        repeat (3) @(posedge i_clk_sys);
        i_suspend <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        i_suspend <= 1'b0;
      end
      begin
        repeat (5) @(negedge i_clk_sys);
        check(o_req_ready === 1'b0, "ready while suspended");
      end
      for (int n = 0; n < 8; n++)
        req('{1'h0, 1'h0, 17'h00030 + n[1:0], 36'h0, 4'hf}, 1'b0);
    join
    stall = 0;
    idle(1);
    drain();
    // Reset in mid-run clears the pipeline but the array keeps its words
    i_reset_n <= 1'b0;
    @(negedge i_clk_sys);
    check(o_req_ready === 1'b0 && o_rsp_valid === 1'b0 && u_zsram_link_if.mem_data_oe === 1'b0, "active in reset");
    repeat (3) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    @(posedge i_clk_sys);
    req('{1'h0, 1'h0, 17'h00010, 36'h0, 4'hf}, 1'b0);
    idle(1);
    drain();
    test_done();
  end
endmodule
